// ===== hw/wtc_consts.vh
`ifndef WTC_CONSTS_VH
`define WTC_CONSTS_VH
`define WTC_ADDR_IWK      7'h06
`define WTC_ADDR_EWK      7'h07
`define WTC_ADDR_PULL     7'h08
`define WTC_ADDR_CAN      7'h0b
`define WTC_ADDR_TMR      7'h0c
`define WTC_RST_IWK       8'h00
`define WTC_RST_EWK       8'h01
`define WTC_RST_PULL      8'h00
`define WTC_RST_CAN       8'h00
`define WTC_RST_TMR       8'h00
`define WTC_MASK_IWK      8'h44
`define WTC_MASK_EWK      8'ha1
`define WTC_MASK_PULL     8'hc3
`define WTC_MASK_CAN      8'h10
`define WTC_MASK_TMR      8'h7f
`define WTC_FAILSAFE_EWK  8'h01
`define WTC_BIT_TMR_WK    6
`define WTC_BIT_WD_OFF    2
`define WTC_BIT_GLOBAL    7
`define WTC_BIT_SENSE     5
`define WTC_BIT_WAKE_PIN_SOURCE_ENABLE     0
`define WTC_BIT_FLASH     4
`define WTC_ON_OFF_LOW    3'h0
`define WTC_ON_OFF_HIGH   3'h6
`define WTC_ON_RSVD       3'h7
`define WTC_CLK_HZ        20000000
`define WTC_TICK_US       100
`define WTC_TICK_CYC      ((`WTC_CLK_HZ / 1000000) * `WTC_TICK_US)
`endif

// ===== hw/wtc_top.v
// Purpose: wake and cyclic timer control registers behind a serial port
// Assumes: mode 0 serial frames of 16 bits: rw bit, 7 bit address, 8 bit data, msb first
// Notes:   serial pins are sampled by clk_i through two flip-flops
// Overview of operation
// R1: timer wake enable bit makes timer wake
// R2: stop mode watchdog off bit two
// R3: stop to normal clears watchdog off bit
// R4: global bit widens interrupt scope
// R5: sense select blocks wake pin events
// R6: wake pin enable bit makes pin wake
// R7: sensing without fail ignores enable and gpio
// R8: sense write refused under fail, fault flag
// R9: sensing holds level status bits reset
// R10: fail-safe entry forces wake pin source
// R11: sensing at fail-safe keeps pin unarmed
// R12: host sets can mode for can wake; no can mode here, the bus speed register holds only the flash mode bit
// R13: gpio wake pull code field 7:6
// R14: wake pin pull code field 1:0
// R15: flash mode bit lifts slew control
// R16: on-time code selects on-time length
// R17: codes 000 and 110 stop timer
// R18: reserved bits ignore writes, read zero
// R19: restart keeps only timer wake enable
// R20: restart clears timer control fully
// R21: restart keeps only flash mode bit
// R22: reset value arms wake pin detection
// R23: period code selects 1-2-5 period
// R24: timer config active at chip select rise
// R25: timer runs once on-time is set
// R26: period end raises timer wake event
`include "wtc_consts.vh"
module wtc_top (
    input  wire       clk_i,
    input  wire       reset_i,
    input  wire       soft_reset_i,
    input  wire       restart_entry_i,
    input  wire       failsafe_entry_i,
    input  wire       stop_to_normal_i,
    input  wire       fail_output_i,
    input  wire       wake_pin_event_i,
    input  wire       wake_pin_level_i,
    input  wire       gpio_level_i,
    input  wire       status_event_i,
    input  wire       spi_csn_i,
    input  wire       spi_sck_i,
    input  wire       spi_mosi_i,
    output reg        spi_miso_o,
    output reg        spi_miso_oe_o,
    output reg        interrupt_out_n_o,
    output reg        serial_access_fault_o,
    output reg        timer_wake_event_o,
    output reg        high_side_switch_out_o,
    output reg        stop_mode_watchdog_off_b1_o,
    output reg        wake_pin_source_active_o,
    output reg        wake_pin_measure_o,
    output reg        wake_pin_level_status_o,
    output reg        gpio_level_status_o,
    output reg        gpio_cfg_ignored_o,
    output reg  [1:0] gpio_wake_pull_select_o,
    output reg  [1:0] wake_pin_pull_select_o,
    output reg        can_flash_mode_o
);
    reg  [2:0]  csn_s;
    reg  [2:0]  sck_s;
    reg  [1:0]  mosi_s;
    reg  [15:0] shift;
    reg  [4:0]  bit_cnt;
    reg  [7:0]  internal_wake_control;
    reg  [7:0]  external_wake_control;
    reg  [7:0]  wake_pull_control;
    reg  [7:0]  can_bus_speed_control;
    reg  [7:0]  cyclic_timer_control;
    reg  [7:0]  rd_data;
    reg  [7:0]  rd_hold;
    reg  [11:0] tick_cnt;
    reg  [23:0] us_cnt;
    reg  [23:0] period_ticks;
    reg  [23:0] on_ticks;
    reg         event_d;
    wire        csn_fall = csn_s[2] & ~csn_s[1];
    wire        csn_rise = ~csn_s[2] & csn_s[1];
    wire        sck_rise = ~sck_s[2] & sck_s[1] & ~csn_s[1];
    wire        sck_fall = sck_s[2] & ~sck_s[1] & ~csn_s[1];
    wire        wr_done  = csn_rise & (bit_cnt == 5'h10) & shift[15];
    wire [6:0]  wr_addr  = shift[14:8];
    wire [7:0]  wr_data  = shift[7:0];
    localparam [31:0] TICK_LAST = `WTC_TICK_CYC - 1;
    wire        tick     = ({20'h00000, tick_cnt} == TICK_LAST);
    wire [2:0]  on_code  = cyclic_timer_control[6:4];
    wire        sensing  = external_wake_control[`WTC_BIT_SENSE];
    // R25: running when on-time neither off nor reserved
    wire        tmr_run  = (on_code != `WTC_ON_OFF_LOW) && (on_code != `WTC_ON_OFF_HIGH)
                           && (on_code != `WTC_ON_RSVD);
    // R23: period in 100 us ticks
    always @* begin
        case (cyclic_timer_control[3:0])
            4'h0:    period_ticks = 24'd100;
            4'h1:    period_ticks = 24'd200;
            4'h2:    period_ticks = 24'd500;
            4'h3:    period_ticks = 24'd1000;
            4'h4:    period_ticks = 24'd2000;
            4'h5:    period_ticks = 24'd5000;
            4'h6:    period_ticks = 24'd10000;
            4'h7:    period_ticks = 24'd20000;
            4'h8:    period_ticks = 24'd50000;
            4'h9:    period_ticks = 24'd100000;
            4'ha:    period_ticks = 24'd200000;
            4'hb:    period_ticks = 24'd500000;
            4'hc:    period_ticks = 24'd1000000;
            4'hd:    period_ticks = 24'd2000000;
            4'he:    period_ticks = 24'd5000000;
            default: period_ticks = 24'd10000000;
        endcase
    end
    // R16: on-time in 100 us ticks
    always @* begin
        case (on_code)
            3'h1:    on_ticks = 24'd1;
            3'h2:    on_ticks = 24'd3;
            3'h3:    on_ticks = 24'd10;
            3'h4:    on_ticks = 24'd100;
            3'h5:    on_ticks = 24'd200;
            default: on_ticks = 24'd0;
        endcase
    end
    // R18: reserved bits read zero
    always @* begin
        case (shift[6:0])
            `WTC_ADDR_IWK:  rd_data = internal_wake_control;
            `WTC_ADDR_EWK:  rd_data = external_wake_control;
            `WTC_ADDR_PULL: rd_data = wake_pull_control;
            `WTC_ADDR_CAN:  rd_data = can_bus_speed_control;
            `WTC_ADDR_TMR:  rd_data = cyclic_timer_control;
            default:        rd_data = 8'h00;
        endcase
    end
    always @(posedge clk_i) begin
        if (reset_i) begin
            csn_s  <= 3'h7;
            sck_s  <= 3'h0;
            mosi_s <= 2'h0;
        end else begin
            csn_s  <= {csn_s[1:0], spi_csn_i};
            sck_s  <= {sck_s[1:0], spi_sck_i};
            mosi_s <= {mosi_s[0], spi_mosi_i};
        end
    end
    // serial shifter, read data loaded after address byte
    always @(posedge clk_i) begin
        if (reset_i) begin
            shift         <= 16'h0000;
            bit_cnt       <= 5'h00;
            spi_miso_o    <= 1'b0;
            spi_miso_oe_o <= 1'b0;
            rd_hold       <= 8'h00;
        end else begin
            spi_miso_oe_o <= ~csn_s[1];
            if (csn_fall) begin
                bit_cnt    <= 5'h00;
                spi_miso_o <= 1'b0;
            end else if (sck_rise && bit_cnt != 5'h10) begin
                shift   <= {shift[14:0], mosi_s[1]};
                bit_cnt <= bit_cnt + 5'h01;
            end else if (sck_fall) begin
                // read byte kept apart so the frame keeps its address
                if (bit_cnt == 5'h08) begin
                    rd_hold    <= rd_data;
                    spi_miso_o <= rd_data[7];
                end else if (bit_cnt > 5'h08 && bit_cnt < 5'h10) begin
                    rd_hold    <= {rd_hold[6:0], 1'b0};
                    spi_miso_o <= rd_hold[6];
                end
            end
        end
    end
    // register bank with reset, restart, fail-safe and write effects
    always @(posedge clk_i) begin
        if (reset_i || soft_reset_i) begin
            // R22: wake pin armed after reset
            internal_wake_control <= `WTC_RST_IWK;
            external_wake_control <= `WTC_RST_EWK;
            wake_pull_control     <= `WTC_RST_PULL;
            can_bus_speed_control <= `WTC_RST_CAN;
            cyclic_timer_control  <= `WTC_RST_TMR;
            serial_access_fault_o <= 1'b0;
        end else if (restart_entry_i) begin
            // R19: keep timer wake enable
            internal_wake_control <= internal_wake_control & 8'h40;
            // R20: timer control cleared
            cyclic_timer_control  <= 8'h00;
            // R21: keep flash bit
            can_bus_speed_control <= can_bus_speed_control & `WTC_MASK_CAN;
        end else begin
            if (wr_done) begin
                case (wr_addr)
                    `WTC_ADDR_IWK:  internal_wake_control <= wr_data & `WTC_MASK_IWK;
                    `WTC_ADDR_EWK: begin
                        // R8: refuse sense select under fail
                        if (fail_output_i && wr_data[`WTC_BIT_SENSE])
                            external_wake_control <= wr_data & `WTC_MASK_EWK & 8'hdf;
                        else
                            external_wake_control <= wr_data & `WTC_MASK_EWK;
                    end
                    // R13: gpio pull field
                    // R14: wake pin pull field
                    `WTC_ADDR_PULL: wake_pull_control     <= wr_data & `WTC_MASK_PULL;
                    `WTC_ADDR_CAN:  can_bus_speed_control <= wr_data & `WTC_MASK_CAN;
                    // R24: takes effect at chip select rise
                    `WTC_ADDR_TMR:  cyclic_timer_control  <= wr_data & `WTC_MASK_TMR;
                    default:        ;
                endcase
            end
            // R8: fault flag sticks until reset
            if (wr_done && wr_addr == `WTC_ADDR_EWK && fail_output_i
                && wr_data[`WTC_BIT_SENSE])
                serial_access_fault_o <= 1'b1;
            // R3: cleared on stop to normal
            if (stop_to_normal_i)
                internal_wake_control[`WTC_BIT_WD_OFF] <= 1'b0;
            // R10: fail-safe arms wake pin
            // R11: not while sensing
            if (failsafe_entry_i && !sensing)
                external_wake_control <= (external_wake_control & 8'ha0) | `WTC_FAILSAFE_EWK;
        end
    end
    // cyclic timer, 100 us tick from divider
    always @(posedge clk_i) begin
        if (reset_i || !tmr_run || wr_done) begin
            tick_cnt <= 12'h000;
            us_cnt   <= 24'h000000;
        end else if (tick) begin
            tick_cnt <= 12'h000;
            us_cnt   <= (us_cnt >= period_ticks - 24'd1) ? 24'h000000 : us_cnt + 24'd1;
        end else begin
            tick_cnt <= tick_cnt + 12'h001;
        end
    end
    always @(posedge clk_i) begin
        if (reset_i) begin
            high_side_switch_out_o      <= 1'b0;
            timer_wake_event_o          <= 1'b0;
            interrupt_out_n_o           <= 1'b1;
            event_d                     <= 1'b0;
            stop_mode_watchdog_off_b1_o <= 1'b0;
            wake_pin_source_active_o    <= 1'b0;
            wake_pin_measure_o          <= 1'b0;
            wake_pin_level_status_o     <= 1'b0;
            gpio_level_status_o         <= 1'b0;
            gpio_cfg_ignored_o          <= 1'b0;
            gpio_wake_pull_select_o     <= 2'h0;
            wake_pin_pull_select_o      <= 2'h0;
            can_flash_mode_o            <= 1'b0;
        end else begin
            // R17: stopped codes fix output level
            high_side_switch_out_o <= (on_code == `WTC_ON_OFF_HIGH) ||
                                      (tmr_run && us_cnt < on_ticks);
            // R1: timer wake only when enabled
            // R26: event at period end
            timer_wake_event_o <= internal_wake_control[`WTC_BIT_TMR_WK] && tmr_run && tick
                                  && (us_cnt >= period_ticks - 24'd1);
            // R5: sensing blocks pin events
            // R6: pin enable gates pin events
            // R7: enable ignored while sensing
            event_d <= timer_wake_event_o ||
                       (wake_pin_event_i && external_wake_control[`WTC_BIT_WAKE_PIN_SOURCE_ENABLE] && !sensing);
            // R4: global scope adds status events
            interrupt_out_n_o <= ~(event_d ||
                                   (external_wake_control[`WTC_BIT_GLOBAL] && status_event_i));
            // R2: watchdog off in stop mode
            stop_mode_watchdog_off_b1_o <= internal_wake_control[`WTC_BIT_WD_OFF];
            wake_pin_source_active_o    <= external_wake_control[`WTC_BIT_WAKE_PIN_SOURCE_ENABLE] && !sensing;
            // R9: measure on, level status held reset
            wake_pin_measure_o      <= sensing;
            wake_pin_level_status_o <= sensing ? 1'b0 : wake_pin_level_i;
            gpio_level_status_o     <= sensing ? 1'b0 : gpio_level_i;
            gpio_cfg_ignored_o      <= sensing && !fail_output_i;
            gpio_wake_pull_select_o <= wake_pull_control[7:6];
            wake_pin_pull_select_o  <= wake_pull_control[1:0];
            // R15: flash mode drive
            can_flash_mode_o <= can_bus_speed_control[`WTC_BIT_FLASH];
        end
    end
endmodule // wtc_top

// ===== tb/wtc_host.sv
// Purpose: serial host framing 16 bit transfers toward the register block
// Assumes: mode 0, msb first, sck period 8 clocks, sck stands still low outside frames
// Notes:   mosi shows the inverse of its last bit once a frame ends
module wtc_host (
    input  wire logic clk_i,
    input  wire logic miso_i,
    output logic      csn_o,
    output logic      sck_o,
    output logic      mosi_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        csn_o  = 1'b1;
        sck_o  = 1'b0;
        mosi_o = 1'b0;
    end
    task automatic xfer(input logic [15:0] word, output logic [7:0] rdata);
        rdata = 8'h00;
        @(posedge clk_i);
        csn_o <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
            repeat (4) @(posedge clk_i);
            sck_o  <= 1'b0;
            mosi_o <= word[i];
            repeat (4) @(posedge clk_i);
            sck_o <= 1'b1;
            if (i < 8) rdata = {rdata[6:0], miso_i};
        end
        repeat (4) @(posedge clk_i);
        sck_o <= 1'b0;
        repeat (4) @(posedge clk_i);
        csn_o  <= 1'b1;
        mosi_o <= ~word[0];
        // register update lands a few clocks after csn rise
        repeat (8) @(posedge clk_i);
    endtask
endmodule // wtc_host

// ===== tb/wtc_chk.sv
// Purpose: port checks on the wake and timer register block
// Assumes: derived outputs follow register updates one clock later
// Notes:   bound to every instance of the block
module wtc_chk (
    input wire logic clk_i, reset_i, soft_reset_i, restart_entry_i, failsafe_entry_i,
    input wire logic stop_to_normal_i, fail_output_i, spi_csn_i, spi_miso_oe_o,
    input wire logic serial_access_fault_o, timer_wake_event_o, interrupt_out_n_o,
    input wire logic high_side_switch_out_o, stop_mode_watchdog_off_b1_o,
    input wire logic wake_pin_source_active_o, wake_pin_measure_o, wake_pin_level_status_o,
    input wire logic gpio_level_status_o, gpio_cfg_ignored_o, can_flash_mode_o,
    input wire logic [1:0] gpio_wake_pull_select_o,
    input wire logic [1:0] wake_pin_pull_select_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    sequence csn_idle; spi_csn_i [*5]; endsequence
    sequence fs_armed; ##2 wake_pin_source_active_o; endsequence
    sequence fs_unarmed; ##2 !wake_pin_source_active_o; endsequence
    oe_idle_a: assert property (csn_idle |-> !spi_miso_oe_o)
        else $error("miso driven while deselected");
    fault_hold_a: assert property (serial_access_fault_o && !soft_reset_i |=> serial_access_fault_o)
        else $error("fault flag dropped");
    level_hold_a: assert property (wake_pin_measure_o && $past(wake_pin_measure_o)
        |-> !wake_pin_level_status_o && !gpio_level_status_o) else $error("level status moved");
    gpio_ignore_a: assert property (gpio_cfg_ignored_o |-> !$past(fail_output_i))
        else $error("ignore under fail");
    wd_clear_a: assert property (stop_to_normal_i |-> ##2 !stop_mode_watchdog_off_b1_o)
        else $error("watchdog off bit kept");
    restart_clr_a: assert property (restart_entry_i
        |-> ##2 !high_side_switch_out_o && !stop_mode_watchdog_off_b1_o) else $error("restart");
    soft_reset_a: assert property (soft_reset_i |-> ##2 wake_pin_pull_select_o == 2'b00
        && !can_flash_mode_o && !serial_access_fault_o) else $error("soft reset values");
    fs_arm_a: assert property (failsafe_entry_i && !wake_pin_measure_o |-> fs_armed)
        else $error("fail-safe left pin unarmed");
    fs_keep_a: assert property (failsafe_entry_i && wake_pin_measure_o |-> fs_unarmed)
        else $error("fail-safe armed sensing pin");
    tmr_pulse_a: assert property (timer_wake_event_o |=> !timer_wake_event_o)
        else $error("timer event too long");
    tmr_irq_a: assert property (timer_wake_event_o |-> ##[1:3] !interrupt_out_n_o)
        else $error("timer event no interrupt");
endmodule // wtc_chk
bind wtc_top wtc_chk chk (.clk_i, .reset_i, .soft_reset_i, .restart_entry_i, .failsafe_entry_i,
    .stop_to_normal_i, .fail_output_i, .spi_csn_i, .spi_miso_oe_o, .serial_access_fault_o,
    .timer_wake_event_o, .interrupt_out_n_o, .high_side_switch_out_o,
    .stop_mode_watchdog_off_b1_o, .wake_pin_source_active_o, .wake_pin_measure_o,
    .wake_pin_level_status_o, .gpio_level_status_o, .gpio_cfg_ignored_o, .can_flash_mode_o,
    .gpio_wake_pull_select_o, .wake_pin_pull_select_o);

// ===== tb/test_wake_and_cyclic_timer_control.sv
// Purpose: self-checking bench for the wake and timer register block
// Assumes: 20 MHz clock, frames through the serial host model
// Notes:   timer periods are too long to run out here
`include "wtc_consts.vh"
module test_wake_and_cyclic_timer_control;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 0, reset_i = 1, soft_reset_i = 0, restart_entry_i = 0, failsafe_entry_i = 0;
    logic stop_to_normal_i = 0, fail_output_i = 0, wake_pin_event_i = 0;
    logic wake_pin_level_i = 1, gpio_level_i = 1, status_event_i = 0;
    logic spi_csn_i, spi_sck_i, spi_mosi_i, spi_miso_o, spi_miso_oe_o, interrupt_out_n_o;
    logic serial_access_fault_o, timer_wake_event_o, high_side_switch_out_o, can_flash_mode_o;
    logic stop_mode_watchdog_off_b1_o, wake_pin_source_active_o, wake_pin_measure_o;
    logic wake_pin_level_status_o, gpio_level_status_o, gpio_cfg_ignored_o;
    logic [1:0] gpio_wake_pull_select_o, wake_pin_pull_select_o;
    logic [6:0] regs [5] = '{7'h06, 7'h07, 7'h08, 7'h0b, 7'h0c};
    int bad_count = 0, num_checks = 0;
    wtc_top DUT (.clk_i, .reset_i, .soft_reset_i, .restart_entry_i, .failsafe_entry_i,
        .stop_to_normal_i, .fail_output_i, .wake_pin_event_i, .wake_pin_level_i, .gpio_level_i,
        .status_event_i, .spi_csn_i, .spi_sck_i, .spi_mosi_i, .spi_miso_o, .spi_miso_oe_o,
        .interrupt_out_n_o, .serial_access_fault_o, .timer_wake_event_o, .high_side_switch_out_o,
        .stop_mode_watchdog_off_b1_o, .wake_pin_source_active_o, .wake_pin_measure_o,
        .wake_pin_level_status_o, .gpio_level_status_o, .gpio_cfg_ignored_o,
        .gpio_wake_pull_select_o, .wake_pin_pull_select_o, .can_flash_mode_o);
    wtc_host host (.clk_i(clk_i), .miso_i(spi_miso_oe_o ? spi_miso_o : 1'b1),
        .csn_o(spi_csn_i), .sck_o(spi_sck_i),
        .mosi_o(spi_mosi_i));
    initial forever #25 clk_i = ~clk_i;
    function automatic logic [7:0] mask_of(input logic [6:0] a);
        case (a)
            `WTC_ADDR_IWK: mask_of = `WTC_MASK_IWK;
            `WTC_ADDR_EWK: mask_of = `WTC_MASK_EWK;
            `WTC_ADDR_PULL: mask_of = `WTC_MASK_PULL;
            `WTC_ADDR_CAN: mask_of = `WTC_MASK_CAN;
            `WTC_ADDR_TMR: mask_of = `WTC_MASK_TMR;
            default: mask_of = 8'h00;
        endcase
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        num_checks++;
        if (seen !== want) begin
            bad_count++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] r;
        host.xfer({1'b1, a, d}, r);
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] want);
        logic [7:0] r;
        host.xfer({1'b0, a, 8'h00}, r);
        check(r, want);
    endtask
    // pin event under a given source setup, low seen within four clocks
    task automatic pin_event(input logic [7:0] cfg, input logic want_n);
        logic seen;
        seen = 1'b1;
        wr(7'h07, cfg);
        @(posedge clk_i) wake_pin_event_i <= 1'b1;
        @(posedge clk_i) wake_pin_event_i <= 1'b0;
        repeat (4) @(negedge clk_i) if (interrupt_out_n_o === 1'b0) seen = 1'b0;
        check({7'h0, seen}, {7'h0, want_n});
    endtask
    task automatic test_done();
        $display("checks=%0d bad=%0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge clk_i);
        bad_count++;
        test_done();
    end
    initial begin
        logic [7:0] d;
        logic [6:0] a;
        void'($urandom(32'h9691));
        repeat (16) @(posedge clk_i);
        reset_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        for (int i = 0; i < 5; i++) rd(regs[i], i == 1 ? 8'h01 : 8'h00);
        wr(7'h20, 8'hff);
        rd(7'h20, 8'h00);
        // all ones first per register, then random values
        for (int i = 0; i < 30; i++) begin
            a = regs[i % 5];
            d = i < 5 ? 8'hff : 8'($urandom);
            wr(a, d);
            rd(a, d & mask_of(a));
            if (a == 7'h08) check({gpio_wake_pull_select_o, wake_pin_pull_select_o}, {d[7:6], d[1:0]});
            if (a == 7'h0b) check({7'h0, can_flash_mode_o}, {7'h0, d[4]});
        end
        wr(7'h0c, 8'h60);
        check({7'h0, high_side_switch_out_o}, 8'h01);
        wr(7'h0c, 8'h00);
        check({7'h0, high_side_switch_out_o}, 8'h00);
        wr(7'h06, 8'h44);
        @(posedge clk_i) stop_to_normal_i <= 1'b1;
        @(posedge clk_i) stop_to_normal_i <= 1'b0;
        rd(7'h06, 8'h40);
        wr(7'h06, 8'h44);
        wr(7'h0b, 8'h10);
        wr(7'h0c, 8'h35);
        @(posedge clk_i) restart_entry_i <= 1'b1;
        @(posedge clk_i) restart_entry_i <= 1'b0;
        rd(7'h06, 8'h40);
        rd(7'h0c, 8'h00);
        rd(7'h0b, 8'h10);
        pin_event(8'h01, 1'b0);
        pin_event(8'h00, 1'b1);
        pin_event(8'h21, 1'b1);
        check({gpio_cfg_ignored_o, wake_pin_level_status_o, gpio_level_status_o}, 8'h04);
        wr(7'h07, 8'h01);
        check({wake_pin_level_status_o, gpio_level_status_o}, 8'h03);
        status_event_i <= 1'b1;
        wr(7'h07, 8'h81);
        check({7'h0, interrupt_out_n_o}, 8'h00);
        wr(7'h07, 8'h01);
        check({7'h0, interrupt_out_n_o}, 8'h01);
        status_event_i <= 1'b0;
        fail_output_i <= 1'b1;
        wr(7'h07, 8'ha0);
        rd(7'h07, 8'h80);
        check({7'h0, serial_access_fault_o}, 8'h01);
        @(posedge clk_i) failsafe_entry_i <= 1'b1;
        @(posedge clk_i) failsafe_entry_i <= 1'b0;
        rd(7'h07, 8'h81);
        fail_output_i <= 1'b0;
        wr(7'h07, 8'h20);
        @(posedge clk_i) failsafe_entry_i <= 1'b1;
        @(posedge clk_i) failsafe_entry_i <= 1'b0;
        rd(7'h07, 8'h20);
        check({7'h0, wake_pin_source_active_o}, 8'h00);
        wr(7'h0c, 8'h10);
        check({7'h0, high_side_switch_out_o}, 8'h01);
        wr(7'h0c, 8'h70);
        check({7'h0, high_side_switch_out_o}, 8'h00);
        wr(7'h0c, 8'h13);
        check({7'h0, high_side_switch_out_o}, 8'h01);
        repeat (2100) @(posedge clk_i);
        check({7'h0, high_side_switch_out_o}, 8'h00);
        wr(7'h08, 8'hc3);
        @(posedge clk_i) soft_reset_i <= 1'b1;
        @(posedge clk_i) soft_reset_i <= 1'b0;
        rd(7'h08, 8'h00);
        rd(7'h07, 8'h01);
        test_done();
    end
endmodule // test_wake_and_cyclic_timer_control
